// ### pattern_register_stagger_read_tb.sv
module pattern_register_stagger_read_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] PAT = prsr_pkg::PATTERN_RST;
   logic clk_sys;
   logic rstn;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic access_en;
   logic [2:0] parity_latency;
   int fail_count = 0;
   int total_checks = 0;
   // ==========================================================
   // Both ends across one link
   prsr_link_if u_prsr_link_if (.clk_sys(clk_sys), .rstn(rstn));
   prsr_device u_prsr_device (.link(u_prsr_link_if), .access_en(access_en),
      .parity_latency(parity_latency));
   prsr_ctrl u_prsr_ctrl (.link(u_prsr_link_if), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   prsr_link_assertions u_prsr_link_assertions (.clk_sys(clk_sys), .rstn(rstn),
      .cmd_rd(u_prsr_link_if.cmd_rd), .cmd_mrs(u_prsr_link_if.cmd_mrs),
      .mr_sel(u_prsr_link_if.mr_sel), .bg0(u_prsr_link_if.bg0), .addr(u_prsr_link_if.addr),
      .dq_o(u_prsr_link_if.dq_o), .dq_oe_n(u_prsr_link_if.dq_oe_n),
      .dqs_o(u_prsr_link_if.dqs_o), .dqs_oe_n(u_prsr_link_if.dqs_oe_n));
   // ==========================================================
   // Sixteen-lane device shadowing the same commands
   prsr_link_if #(.LANES(16)) u_wide_link_if (.clk_sys(clk_sys), .rstn(rstn));
   prsr_device #(.LANES(16)) u_prsr_device_wide (.link(u_wide_link_if), .access_en(),
      .parity_latency());
   assign u_wide_link_if.cmd_rd = u_prsr_link_if.cmd_rd;
   assign u_wide_link_if.cmd_mrs = u_prsr_link_if.cmd_mrs;
   assign u_wide_link_if.mr_sel = u_prsr_link_if.mr_sel;
   assign u_wide_link_if.ba = u_prsr_link_if.ba;
   assign u_wide_link_if.bg0 = u_prsr_link_if.bg0;
   assign u_wide_link_if.addr = u_prsr_link_if.addr;
   // Every group of four lanes must repeat the checked nibble
   always @(negedge clk_sys) begin
      if (rstn && !(u_wide_link_if.dq_oe_n && u_prsr_link_if.dq_oe_n)) begin
         total_checks++;
         if ({u_wide_link_if.dq_oe_n, u_wide_link_if.dq_o} !==
               {u_prsr_link_if.dq_oe_n, {4{u_prsr_link_if.dq_o}}}) begin
            fail_count++;
            $display("wrong value at %0t: wide lanes differ from nibble", $time);
         end
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask : rd_reg
   // Mode writes land on the device two edges later
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle
   task automatic wait_status(input logic [31:0] mask, input logic [31:0] val);
      logic [31:0] s;
      for (int i = 0; i < 60; i++) begin
         rd_reg(prsr_pkg::REG_STATUS, s);
         if ((s & mask) === val) return;
      end
      fail_count++;
      $display("wrong value at %0t: status never reached", $time);
      end_of_test();
   endtask : wait_status
   // Lane k, UI u carries bit u of location (loc + k) mod 4
   function automatic logic [31:0] exp_word(input logic [1:0] loc);
      logic [31:0] w;
      logic [1:0] l;
      for (int k = 0; k < 4; k++) begin
         l = loc + 2'(k);
         for (int u = 0; u < 8; u++) w[u*4+k] = PAT[8*l+u];
      end
      return w;
   endfunction : exp_word
   task automatic check_loc(input logic [1:0] loc);
      logic [31:0] d;
      wr_reg(prsr_pkg::REG_READ, {30'h0, loc});
      wait_status(32'h2, 32'h2);
      rd_reg(prsr_pkg::REG_DATA, d);
      chk(d, exp_word(loc), "burst word");
      wr_reg(prsr_pkg::REG_POP, 32'h0);
   endtask : check_loc
   // ==========================================================
   // Scenarios
   task automatic sc_reset();
      logic [31:0] s;
      rd_reg(prsr_pkg::REG_STATUS, s);
      chk(s & 32'h707, 32'h1, "status after reset");
      chk({31'h0, u_prsr_link_if.dq_oe_n}, 32'h1, "idle data enable");
      rd_reg(8'hfc, s);
      chk(s, 32'h0, "unmapped read");
   endtask : sc_reset
   task automatic sc_stagger();
      wr_reg(prsr_pkg::REG_MR3, 32'h4);
      settle();
      chk({31'h0, access_en}, 32'h1, "access on");
      for (int l = 0; l < 4; l++) check_loc(2'(l));
   endtask : sc_stagger
   task automatic sc_on_the_fly();
      logic [31:0] s;
      wr_reg(prsr_pkg::REG_MR0, 32'h1);
      rd_reg(prsr_pkg::REG_MR0, s);
      chk(s & 32'h3, 32'h1, "burst field");
      check_loc(2'h3);
      wr_reg(prsr_pkg::REG_MR0, 32'h0);
   endtask : sc_on_the_fly
   task automatic sc_parity();
      wr_reg(prsr_pkg::REG_MR5, 32'h3);
      settle();
      chk({29'h0, parity_latency}, 32'h3, "parity latency");
      check_loc(2'h1);
      wr_reg(prsr_pkg::REG_MR5, 32'h0);
   endtask : sc_parity
   task automatic sc_back_to_back();
      logic [1:0] locs [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
      logic [31:0] s;
      // One read per eight cycles keeps bursts gapless; the fifth finds no credit
      foreach (locs[i]) begin
         wr_reg(prsr_pkg::REG_READ, {30'h0, locs[i]});
         repeat (6) @(posedge clk_sys);
      end
      wait_status(32'h700, 32'h400);
      rd_reg(prsr_pkg::REG_STATUS, s);
      chk(s & 32'h4, 32'h4, "refused read flagged");
      wr_reg(prsr_pkg::REG_STATUS, 32'h4);
      rd_reg(prsr_pkg::REG_STATUS, s);
      chk(s & 32'h4, 32'h0, "drop cleared");
      for (int i = 0; i < 4; i++) begin
         rd_reg(prsr_pkg::REG_DATA, s);
         chk(s, exp_word(locs[i]), "streamed word");
         wr_reg(prsr_pkg::REG_POP, 32'h0);
      end
   endtask : sc_back_to_back
   task automatic sc_disable();
      int lows = 0;
      wr_reg(prsr_pkg::REG_MR3, 32'h0);
      settle();
      chk({31'h0, access_en}, 32'h0, "access off");
      wr_reg(prsr_pkg::REG_READ, 32'h0);
      repeat (30) begin
         @(negedge clk_sys);
         if (u_prsr_link_if.dq_oe_n !== 1'b1) lows++;
      end
      chk(32'(lows), 32'h0, "data while disabled");
   endtask : sc_disable
   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      sc_reset();
      sc_stagger();
      sc_on_the_fly();
      sc_parity();
      sc_back_to_back();
      sc_disable();
      end_of_test();
   end
endmodule : pattern_register_stagger_read_tb

// ### prsr_ctrl.sv
// ==========================================================
// Burst FIFO
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
module prsr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = prsr_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic push;
   logic pop;

   assign in_ready = count < ($clog2(DEPTH+1))'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
         end
         count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule : prsr_fifo

// ==========================================================
// Controller end
module prsr_ctrl #(
   parameter int LANES = prsr_pkg::LANES,
   parameter int DEPTH = prsr_pkg::FIFO_DEPTH
) (
   prsr_link_if.ctl link,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   localparam int BW = LANES * prsr_pkg::UI_PER_BURST;
   localparam int CW = $clog2(DEPTH+1);
   localparam int WORDS = (BW + 31) / 32;

   logic [1:0] mr0_bl_reg;
   logic [2:0] gap_reg;
   logic [CW-1:0] outst_reg;
   logic drop_reg;
   logic [2:0] cap_ui_reg;
   logic [BW-1:0] cap_reg;
   logic [BW-1:0] push_data;
   logic [BW-1:0] head_data;
   logic [WORDS*32-1:0] head_wide;
   logic [CW-1:0] fifo_count;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic push;
   logic credit;
   logic read_req;
   logic issue;
   logic pop;
   logic drop_clr;
   logic [7:0] data_off;

   // ==========================================================
   // Issue gating
   // Credit counts bursts in flight and queued so the FIFO never overflows
   assign credit = (outst_reg + fifo_count) < CW'(DEPTH);
   assign read_req = wr && addr == prsr_pkg::REG_READ;
   assign issue = read_req && credit && fifo_in_ready && gap_reg == 3'h0;
   assign pop = wr && addr == prsr_pkg::REG_POP;
   assign drop_clr = wr && addr == prsr_pkg::REG_STATUS && wdata[prsr_pkg::ST_DROP_BIT];
   assign push = !link.dq_oe_n && cap_ui_reg == 3'h7;
   assign push_data = {link.dq_o, cap_reg[BW-LANES-1:0]};
   assign head_wide = (WORDS*32)'(head_data);
   assign data_off = addr - prsr_pkg::REG_DATA;

   // ==========================================================
   // Command bus
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         link.cmd_rd <= 1'b0;
         link.cmd_mrs <= 1'b0;
         link.mr_sel <= 3'h0;
         link.ba <= 2'h0;
         link.bg0 <= 1'b0;
         link.addr <= 14'h0;
         mr0_bl_reg <= 2'h0;
      end else begin
         link.cmd_rd <= issue;
         link.cmd_mrs <= 1'b0;
         if (wr && (addr == prsr_pkg::REG_MR0 || addr == prsr_pkg::REG_MR3 ||
               addr == prsr_pkg::REG_MR5)) begin
            // Disable through MR3 makes the device drop later read commands, so no burst follows them
            link.cmd_mrs <= 1'b1;
            link.mr_sel <= addr[4:2] == 3'h0 ? prsr_pkg::MR_SEL_0 :
                  addr[4:2] == 3'h1 ? prsr_pkg::MR_SEL_3 : prsr_pkg::MR_SEL_5;
            link.addr <= wdata[13:0];
            if (addr == prsr_pkg::REG_MR0) begin
               mr0_bl_reg <= wdata[prsr_pkg::MR0_BL_LSB +: 2];
            end
         end else if (issue) begin
            link.ba <= wdata[1:0];
            link.bg0 <= 1'b0;
            link.addr <= 14'h0;
            link.addr[prsr_pkg::ADDR_A12] <= mr0_bl_reg == prsr_pkg::BL_ON_THE_FLY;
         end
      end
   end

   // ==========================================================
   // Spacing and flight accounting
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         gap_reg <= 3'h0;
         outst_reg <= '0;
         drop_reg <= 1'b0;
      end else begin
         // One burst per read slot keeps the data bus full, never overlapped
         gap_reg <= issue ? 3'(prsr_pkg::UI_PER_BURST - 1) :
               (gap_reg != 3'h0 ? gap_reg - 3'h1 : 3'h0);
         outst_reg <= outst_reg + (issue ? 1'b1 : 1'b0) - (push ? 1'b1 : 1'b0);
         drop_reg <= (read_req && !issue) || (drop_reg && !drop_clr);
      end
   end

   // ==========================================================
   // Capture, valid while the device drives the lanes
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         cap_ui_reg <= 3'h0;
         cap_reg <= '0;
      end else if (!link.dq_oe_n) begin
         cap_reg[cap_ui_reg*LANES +: LANES] <= link.dq_o;
         cap_ui_reg <= cap_ui_reg + 3'h1;
      end
   end

   prsr_fifo #(
      .WIDTH(BW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys(link.clk_sys),
      .rstn(link.rstn),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(head_data),
      .count(fifo_count)
   );

   // ==========================================================
   // Register read port
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         rdata <= 32'h0;
      end else if (rd) begin
         rdata <= 32'h0;
         if (addr == prsr_pkg::REG_STATUS) begin
            rdata[prsr_pkg::ST_READY_BIT] <= credit && fifo_in_ready && gap_reg == 3'h0;
            rdata[prsr_pkg::ST_VALID_BIT] <= fifo_out_valid;
            rdata[prsr_pkg::ST_DROP_BIT] <= drop_reg;
            rdata[prsr_pkg::ST_OUTST_LSB +: CW] <= outst_reg;
            rdata[prsr_pkg::ST_COUNT_LSB +: CW] <= fifo_count;
         end else if (addr == prsr_pkg::REG_MR0) begin
            rdata[1:0] <= mr0_bl_reg;
         end else if (addr >= prsr_pkg::REG_DATA && int'(data_off[7:2]) < WORDS) begin
            rdata <= head_wide[data_off[7:2]*32 +: 32];
         end
      end
   end

endmodule : prsr_ctrl

// ### prsr_device.sv
module prsr_device #(
   parameter int LANES = prsr_pkg::LANES,
   parameter int CL = prsr_pkg::CL_CYCLES,
   parameter logic [31:0] PATTERN = prsr_pkg::PATTERN_RST
) (
   prsr_link_if.dev link,
   output logic access_en,
   output logic [2:0] parity_latency
);
   localparam int DLY = CL + prsr_pkg::PARITY_LAT_MAX;

   prsr_pkg::prsr_burst_e state_reg;
   logic [DLY-1:0] pipe_vld_reg;
   logic [1:0] pipe_loc_reg [DLY];
   logic [1:0] loc_reg;
   logic [2:0] ui_reg;
   logic start;
   logic [1:0] start_loc;
   int tap;

   // ==========================================================
   // Lane pattern
   // Lane k wraps every four lanes, so wider parts repeat the nibble
   function automatic logic [LANES-1:0] stagger(input logic [1:0] loc, input logic [2:0] ui);
      logic [1:0] l;
      logic [4:0] idx;
      stagger = '0;
      for (int k = 0; k < LANES; k++) begin
         l = loc + 2'(k % prsr_pkg::NUM_LOC);
         idx = {l, ui};
         stagger[k] = PATTERN[idx];
      end
   endfunction : stagger

   // ==========================================================
   // Mode registers
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         access_en <= 1'b0;
         parity_latency <= 3'h0;
      end else if (link.cmd_mrs) begin
         if (link.mr_sel == prsr_pkg::MR_SEL_3) begin
            access_en <= link.addr[prsr_pkg::MR3_PR_EN_BIT];
         end
         if (link.mr_sel == prsr_pkg::MR_SEL_5) begin
            parity_latency <= link.addr[prsr_pkg::MR5_PARITY_LAT_LSB +: 3];
         end
      end
   end

   // ==========================================================
   // Latency pipeline
   // Only the read command, gated by access_en, and the bank-address bits enter it; all other pins are dropped here
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         pipe_vld_reg <= '0;
         for (int j = 0; j < DLY; j++) begin
            pipe_loc_reg[j] <= 2'h0;
         end
      end else begin
         pipe_vld_reg[0] <= link.cmd_rd && access_en;
         pipe_loc_reg[0] <= link.ba;
         for (int j = 1; j < DLY; j++) begin
            pipe_vld_reg[j] <= pipe_vld_reg[j-1];
            pipe_loc_reg[j] <= pipe_loc_reg[j-1];
         end
      end
   end

   // Output flops add the last cycle, so UI0 lands CL plus parity_latency cycles after the command
   always_comb begin
      tap = CL - 2 + int'(parity_latency);
      start = pipe_vld_reg[tap];
      start_loc = pipe_loc_reg[tap];
   end

   // ==========================================================
   // Burst output
   always_ff @(posedge link.clk_sys or negedge link.rstn) begin
      if (!link.rstn) begin
         state_reg <= prsr_pkg::PRSR_IDLE;
         loc_reg <= 2'h0;
         ui_reg <= 3'h0;
         link.dq_o <= '0;
         link.dq_oe_n <= 1'b1;
         link.dqs_o <= 1'b0;
         link.dqs_oe_n <= 1'b1;
      end else begin
         unique case (state_reg)
            prsr_pkg::PRSR_IDLE: begin
               if (start) begin
                  state_reg <= prsr_pkg::PRSR_BURST;
                  loc_reg <= start_loc;
                  ui_reg <= 3'h1;
                  link.dq_o <= stagger(start_loc, 3'h0);
                  link.dq_oe_n <= 1'b0;
                  link.dqs_o <= 1'b1;
                  link.dqs_oe_n <= 1'b0;
               end
            end
            prsr_pkg::PRSR_BURST: begin
               if (start) begin
                  // Next burst joins the last UI with no gap
                  loc_reg <= start_loc;
                  ui_reg <= 3'h1;
                  link.dq_o <= stagger(start_loc, 3'h0);
                  link.dqs_o <= 1'b1;
               end else if (ui_reg != 3'h0) begin
                  ui_reg <= ui_reg + 3'h1;
                  link.dq_o <= stagger(loc_reg, ui_reg);
                  link.dqs_o <= ~link.dqs_o;
               end else begin
                  state_reg <= prsr_pkg::PRSR_IDLE;
                  link.dq_o <= '0;
                  link.dq_oe_n <= 1'b1;
                  link.dqs_o <= 1'b0;
                  link.dqs_oe_n <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule : prsr_device

// ### prsr_link_assertions.sv
module prsr_link_assertions #(
   parameter int LANES = prsr_pkg::LANES,
   parameter int CL = prsr_pkg::CL_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cmd_rd,
   input wire logic cmd_mrs,
   input wire logic [2:0] mr_sel,
   input wire logic bg0,
   input wire logic [13:0] addr,
   input wire logic [LANES-1:0] dq_o,
   input wire logic dq_oe_n,
   input wire logic dqs_o,
   input wire logic dqs_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Shadow of mode registers and read history
   logic [17:0] hist_reg;
   logic en_reg;
   logic [2:0] par_lat_reg;
   logic [1:0] bl_reg;
   logic active;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         hist_reg <= '0;
      else
         hist_reg <= {hist_reg[16:0], cmd_rd & en_reg};
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         en_reg <= 1'b0;
         par_lat_reg <= 3'h0;
         bl_reg <= 2'h0;
      end else if (cmd_mrs) begin
         if (mr_sel == prsr_pkg::MR_SEL_3) en_reg <= addr[prsr_pkg::MR3_PR_EN_BIT];
         if (mr_sel == prsr_pkg::MR_SEL_5)
            par_lat_reg <= addr[prsr_pkg::MR5_PARITY_LAT_LSB +: 3];
         if (mr_sel == prsr_pkg::MR_SEL_0) bl_reg <= addr[1:0];
      end
   end
   // Eight UIs behind the latency; assumes no latency change mid-read
   assign active = |((hist_reg >> (CL - 1 + 32'(par_lat_reg))) & 18'h000ff);
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_oe_burst_window: assert property (dq_oe_n == !active)
      else $error("data enable outside the read window");
   a_first_ui_strobe: assert property (hist_reg[CL - 1 + 32'(par_lat_reg)] |->
         dqs_o && !dqs_oe_n)
      else $error("first UI without strobe high");
   a_burst_eight: assert property ($fell(dq_oe_n) |-> !dq_oe_n [*8])
      else $error("burst shorter than eight UIs");
   a_dqs_toggles: assert property (!dqs_oe_n && $past(!dqs_oe_n) |->
         dqs_o != $past(dqs_o))
      else $error("strobe did not toggle");
   a_strobe_pair: assert property (dqs_oe_n == dq_oe_n)
      else $error("strobe and data enables differ");
   a_idle_quiet: assert property (dq_oe_n |-> dq_o == '0 && !dqs_o)
      else $error("lines not quiet while released");
   a_bg0_low: assert property (cmd_rd |-> !bg0)
      else $error("bank group bit set on read");
   a_a12_on_fly: assert property (cmd_rd && bl_reg == prsr_pkg::BL_ON_THE_FLY |->
         addr[12])
      else $error("A12 low with on-the-fly burst");
   a_read_spacing: assert property (cmd_rd |=> !cmd_rd [*7])
      else $error("reads closer than one burst");
   c_gapless: cover property (cmd_rd && en_reg ##8 cmd_rd);
   c_parity: cover property (cmd_rd && en_reg && par_lat_reg != 3'h0);
   c_disabled: cover property (cmd_rd && !en_reg);
endmodule : prsr_link_assertions

// ### prsr_link_if.sv
interface prsr_link_if #(
   parameter int LANES = prsr_pkg::LANES
) (
   input wire logic clk_sys,
   input wire logic rstn
);
   logic cmd_rd;
   logic cmd_mrs;
   logic [2:0] mr_sel;
   logic [1:0] ba;
   logic bg0;
   logic [13:0] addr;
   logic [LANES-1:0] dq_o;
   logic dq_oe_n;
   logic dqs_o;
   logic dqs_oe_n;

   modport dev (
      input clk_sys, rstn, cmd_rd, cmd_mrs, mr_sel, ba, bg0, addr,
      output dq_o, dq_oe_n, dqs_o, dqs_oe_n
   );

   modport ctl (
      input clk_sys, rstn, dq_o, dq_oe_n, dqs_o, dqs_oe_n,
      output cmd_rd, cmd_mrs, mr_sel, ba, bg0, addr
   );
endinterface : prsr_link_if

// ### prsr_pkg.sv
package prsr_pkg;

   // ==========================================================
   // Link geometry
   localparam int LANES = 4;
   localparam int UI_PER_BURST = 8;
   localparam int NUM_LOC = 4;
   localparam int FIFO_DEPTH = 4;

   // ==========================================================
   // Latency, in clk_sys cycles from command to first UI
   localparam int CL_CYCLES = 4;
   localparam int PARITY_LAT_MAX = 7;

   // ==========================================================
   // Mode register selects and field positions
   localparam logic [2:0] MR_SEL_0 = 3'h0;
   localparam logic [2:0] MR_SEL_3 = 3'h3;
   localparam logic [2:0] MR_SEL_5 = 3'h5;
   localparam int MR0_BL_LSB = 0;
   localparam int MR3_PR_EN_BIT = 2;
   localparam int MR5_PARITY_LAT_LSB = 0;
   localparam int ADDR_A12 = 12;
   localparam logic [1:0] BL_ON_THE_FLY = 2'h1;

   // ==========================================================
   // Pattern locations at reset, location i in bits [8i+7:8i]
   localparam logic [31:0] PATTERN_RST = 32'h5533_0fa5;

   // ==========================================================
   // Controller register map
   localparam logic [7:0] REG_MR0 = 8'h00;
   localparam logic [7:0] REG_MR3 = 8'h04;
   localparam logic [7:0] REG_MR5 = 8'h08;
   localparam logic [7:0] REG_READ = 8'h0c;
   localparam logic [7:0] REG_POP = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_DATA = 8'h18;
   localparam int ST_READY_BIT = 0;
   localparam int ST_VALID_BIT = 1;
   localparam int ST_DROP_BIT = 2;
   localparam int ST_OUTST_LSB = 4;
   localparam int ST_COUNT_LSB = 8;

   typedef enum logic [1:0] {
      PRSR_IDLE = 2'b01,
      PRSR_BURST = 2'b10
   } prsr_burst_e;

endpackage : prsr_pkg
